// file: logic/ocf_pkg.sv
// constants and types shared by the overcurrent fault limit and response block
// Function
// - A threshold write lands on the one phase named by the phase selector when that selector is 0x00 to 0x03.
// - The comparator only realises thresholds from 8 A to 62 A in steps of 2 A.
// - The threshold word is read in linear format with a 0.25 A step and accepts 0 to 62 A.
// - The stack current limit is the lowest phase threshold times the number of phases.
// - Any overcurrent fault pulls the alert low and sets the fault status bit, whatever the response code.
// - Response code 00 keeps the output regulating through the fault.
// - Response code 10 keeps the output on for the selected delay, then shuts it down.
// - Response code 11 shuts the output down at once.
// - Retry code 000 latches the output off until the fault is cleared.
// - Retry code 001 makes one restart attempt, then stays off until the fault is cleared.
// - Retry codes 010 and 011 make two or three attempts, then stay off until reset.
// - Retry codes 100 to 110 make four to six attempts, then stay off until reset.
// - Retry code 111 restarts without limit until the output is disabled or reset.
// - The timing code gives a delay of 1, 3 or 7 switching periods for codes 0-1, 2-4 and 5-7.
package ocf_pkg;

   // ======================================================================
   // register map and reset values
   localparam int         NPH        = 4;
   localparam logic [7:0] CMD_PHASE  = 8'h04;
   localparam logic [7:0] CMD_OC_LIM = 8'h46;
   localparam logic [7:0] CMD_OC_ACT = 8'h47;
   localparam logic [7:0] PHASE_MAX  = 8'h03;
   localparam logic [7:0] PHASE_ALL  = 8'hFF;
   localparam logic [7:0] PHASE_RST  = 8'hFF;
   localparam logic [15:0] LIM_RST   = 16'hF0F8;
   localparam logic [7:0] ACT_RST    = 8'hC0;

   // ======================================================================
   // action field layout and codes
   localparam int         ACT_RESP_HI  = 7;
   localparam int         ACT_RESP_LO  = 6;
   localparam int         ACT_RETRY_HI = 5;
   localparam int         ACT_RETRY_LO = 3;
   localparam int         ACT_TIME_HI  = 2;
   localparam int         ACT_TIME_LO  = 0;
   localparam logic [1:0] RESP_DELAY   = 2'h2;
   localparam logic [1:0] RESP_NOW     = 2'h3;
   localparam logic [2:0] RETRY_ONCE   = 3'h1;
   localparam logic [2:0] RETRY_EVER   = 3'h7;

   // ======================================================================
   // current scale, in quarter amps
   localparam int                CUR_W     = 10;
   localparam int                TOT_W     = 12;
   localparam logic signed [5:0] LIN_BIAS  = 6'sh02;
   localparam logic [CUR_W-1:0]  LIM_MIN_Q = 10'h020;
   localparam logic [CUR_W-1:0]  LIM_MAX_Q = 10'h0F8;
   localparam logic [CUR_W-1:0]  LIM_MASK  = 10'h3F8;

   // ======================================================================
   // timing
   localparam int               CLK_NS   = 4;
   localparam int               PWM_NS   = 2000;
   localparam int               PWM_CYC  = (PWM_NS + CLK_NS - 1) / CLK_NS;
   localparam int               PWM_W    = 9;
   localparam int               RISE_NS  = 1000;
   localparam int               TMR_W    = 11;
   localparam logic [TMR_W-1:0] RISE_CYC = TMR_W'((RISE_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [TMR_W-1:0] DLY_1    = 11'h001;
   localparam logic [TMR_W-1:0] DLY_3    = 11'h003;
   localparam logic [TMR_W-1:0] DLY_7    = 11'h007;

   typedef enum logic [2:0] {ST_IDLE, ST_RUN, ST_DELAY, ST_HICCUP, ST_RISE, ST_OFF} ocf_state_t;

endpackage

// file: logic/ocf_cmp_if.sv
// thresholds out to the phase comparators and their verdicts back
interface ocf_cmp_if;
   import ocf_pkg::*;
   logic [15:0]      limit  [NPH];
   logic [CUR_W-1:0] real_q [NPH];
   logic             over   [NPH];
   modport bank (output limit, input real_q, input over);
   modport cmp  (input limit, output real_q, output over);
endinterface

// file: logic/ocf_cmp.sv
// per-phase threshold realisation and peak current comparison
module ocf_cmp (
   input wire logic                                      clk,
   input wire logic                                      rst,
   input wire logic [ocf_pkg::NPH-1:0][ocf_pkg::CUR_W-1:0] peak_cur,
   ocf_cmp_if.cmp                                         b
);
   import ocf_pkg::*;

   // negative mantissas read as zero; large exponents saturate
   function automatic logic [CUR_W-1:0] realise(input logic [15:0] w);
      logic signed [5:0] k;
      logic [17:0]       q;
      logic [CUR_W-1:0]  r;
      k = $signed({w[15], w[15:11]}) + LIN_BIAS;
      if (w[10])
         q = '0;
      else if (k < 0)
         q = {7'h00, w[10:0]} >> 6'(-k);
      else
         q = {7'h00, w[10:0]} << ((k > 6'sh07) ? 3'h7 : 3'(k));
      r = (q > 18'(LIM_MAX_Q)) ? LIM_MAX_Q : q[CUR_W-1:0];
      r = r & LIM_MASK;
      if (r < LIM_MIN_Q)
         r = LIM_MIN_Q;
      return r;
   endfunction

   generate
      for (genvar i = 0; i < NPH; i++) begin : g_ph
         logic [CUR_W-1:0] next_real;
         logic             next_over;
         always_comb begin
            next_real = realise(b.limit[i]);
            next_over = peak_cur[i] > next_real;
         end
         always_ff @(posedge clk or posedge rst) begin
            if (rst) begin
               b.real_q[i] <= LIM_MAX_Q;
               b.over[i]   <= 1'b0;
            end else begin
               b.real_q[i] <= next_real;
               b.over[i]   <= next_over;
            end
         end
         a_realised_grid: assert property (@(posedge clk) disable iff (rst)
            b.real_q[i] >= LIM_MIN_Q && b.real_q[i] <= LIM_MAX_Q && b.real_q[i][2:0] == 3'h0)
            else $error("realised threshold off the 2 A grid");
         a_linear_lsb: assert property (@(posedge clk) disable iff (rst)
            (b.limit[i][15:11] == 5'h1E && b.limit[i][10:0] >= 11'h020 && b.limit[i][10:0] <= 11'h0F8)
            |=> b.real_q[i] == ($past(b.limit[i][9:0]) & LIM_MASK))
            else $error("quarter amp step misread");
         a_over_detect: assert property (@(posedge clk) disable iff (rst)
            $stable(b.limit[i]) |=> b.over[i] == ($past(peak_cur[i]) > $past(b.real_q[i])))
            else $error("over flag disagrees with realised threshold");
      end
   endgenerate

endmodule

// file: logic/ocf_timer.sv
// down counter for shutdown delay, hiccup gap and rise time
module ocf_timer (
   input  wire logic                       clk,
   input  wire logic                       rst,
   input  wire logic                       load,
   input  wire logic [ocf_pkg::TMR_W-1:0]  load_val,
   input  wire logic                       tick,
   output logic                            done
);
   import ocf_pkg::*;

   logic [TMR_W-1:0] cnt;
   logic [TMR_W-1:0] next_cnt;
   logic             busy;
   logic             next_busy;
   logic             next_done;

   // a reload restarts the count, so a newer request always wins
   always_comb begin
      next_cnt  = cnt;
      next_busy = busy;
      next_done = 1'b0;
      if (load) begin
         next_cnt  = load_val;
         next_busy = 1'b1;
      end else if (busy && tick) begin
         if (cnt <= 11'h001) begin
            next_busy = 1'b0;
            next_done = 1'b1;
         end else begin
            next_cnt = cnt - 11'h001;
         end
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cnt  <= '0;
         busy <= 1'b0;
         done <= 1'b0;
      end else begin
         cnt  <= next_cnt;
         busy <= next_busy;
         done <= next_done;
      end
   end

endmodule

// file: logic/ocf_top.sv
// overcurrent fault threshold bank and fault response sequencer
module ocf_top (
   input  wire logic                                         CLK,
   input  wire logic                                         SYS_RST,
   input  wire logic [7:0]                                   CMD_CODE,
   input  wire logic [15:0]                                  CMD_WDATA,
   input  wire logic                                         CMD_WR,
   input  wire logic                                         CMD_RD,
   input  wire logic [ocf_pkg::NPH-1:0][ocf_pkg::CUR_W-1:0]  PEAK_CUR,
   input  wire logic                                         OP_ENABLE,
   input  wire logic                                         FAULT_CLEAR,
   output logic [15:0]                                       RD_DATA,
   output logic                                              RD_VALID,
   output logic                                              OUT_ENABLE,
   output logic                                              ALERT_OUT_N,
   output logic                                              STATUS_OC_FAULT,
   output logic [ocf_pkg::TOT_W-1:0]                         TOTAL_LIMIT
);
   import ocf_pkg::*;

   ocf_cmp_if b ();

   // ======================================================================
   // phase comparators and shared timer
   logic             tmr_load;
   logic [TMR_W-1:0] tmr_val;
   logic             tmr_tick;
   logic             tmr_done;

   ocf_cmp u_cmp (
      .clk      (CLK),
      .rst      (SYS_RST),
      .peak_cur (PEAK_CUR),
      .b        (b.cmp)
   );

   ocf_timer u_tmr (
      .clk      (CLK),
      .rst      (SYS_RST),
      .load     (tmr_load),
      .load_val (tmr_val),
      .tick     (tmr_tick),
      .done     (tmr_done)
   );

   // ======================================================================
   // switching period enable
   logic [PWM_W-1:0] pwm_cnt;
   logic [PWM_W-1:0] next_pwm_cnt;
   logic             pwm_tick;
   logic             next_pwm_tick;

   always_comb begin
      next_pwm_tick = pwm_cnt == PWM_W'(PWM_CYC - 1);
      next_pwm_cnt  = next_pwm_tick ? '0 : pwm_cnt + 9'h001;
   end

   always_ff @(posedge CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         pwm_cnt  <= '0;
         pwm_tick <= 1'b0;
      end else begin
         pwm_cnt  <= next_pwm_cnt;
         pwm_tick <= next_pwm_tick;
      end
   end

   // ======================================================================
   // command registers
   logic [7:0]       phase;
   logic [7:0]       next_phase;
   logic [7:0]       act;
   logic [7:0]       next_act;
   logic [15:0]      next_limit [NPH];
   logic [15:0]      next_rd_data;
   logic [1:0]       idx;
   logic             ph_one;
   logic             ph_all;
   logic [CUR_W-1:0] min_q;
   logic [TOT_W-1:0] next_total;

   always_comb begin
      idx    = phase[1:0];
      ph_one = phase <= PHASE_MAX;
      ph_all = phase == PHASE_ALL;
      for (int i = 0; i < NPH; i++) begin
         next_limit[i] = b.limit[i];
         if (CMD_WR && CMD_CODE == CMD_OC_LIM && (ph_all || (ph_one && idx == 2'(i))))
            next_limit[i] = CMD_WDATA;
      end
      next_phase = phase;
      // selector values that name no phase are refused and the old one kept
      if (CMD_WR && CMD_CODE == CMD_PHASE && (CMD_WDATA[7:0] <= PHASE_MAX || CMD_WDATA[7:0] == PHASE_ALL))
         next_phase = CMD_WDATA[7:0];
      next_act = act;
      if (CMD_WR && CMD_CODE == CMD_OC_ACT)
         next_act = CMD_WDATA[7:0];
      next_rd_data = RD_DATA;
      if (CMD_RD) begin
         unique case (CMD_CODE)
            CMD_PHASE:  next_rd_data = {8'h00, phase};
            CMD_OC_LIM: next_rd_data = ph_one ? b.limit[idx] : b.limit[0];
            CMD_OC_ACT: next_rd_data = {8'h00, act};
            default:    next_rd_data = 16'h0000;
         endcase
      end
      min_q = b.real_q[0];
      for (int i = 1; i < NPH; i++)
         if (b.real_q[i] < min_q)
            min_q = b.real_q[i];
      next_total = TOT_W'(min_q) * TOT_W'(NPH);
   end

   always_ff @(posedge CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         phase       <= PHASE_RST;
         act         <= ACT_RST;
         RD_DATA     <= 16'h0000;
         RD_VALID    <= 1'b0;
         TOTAL_LIMIT <= '0;
         for (int i = 0; i < NPH; i++)
            b.limit[i] <= LIM_RST;
      end else begin
         phase       <= next_phase;
         act         <= next_act;
         RD_DATA     <= next_rd_data;
         RD_VALID    <= CMD_RD;
         TOTAL_LIMIT <= next_total;
         for (int i = 0; i < NPH; i++)
            b.limit[i] <= next_limit[i];
      end
   end

   // ======================================================================
   // fault status and alert
   logic over_any;
   logic next_status;

   always_comb begin
      over_any = 1'b0;
      for (int i = 0; i < NPH; i++)
         over_any = over_any | b.over[i];
      // a fault in the clearing cycle keeps the bit set
      next_status = over_any | (STATUS_OC_FAULT & ~FAULT_CLEAR);
   end

   always_ff @(posedge CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         STATUS_OC_FAULT <= 1'b0;
         ALERT_OUT_N     <= 1'b1;
      end else begin
         STATUS_OC_FAULT <= next_status;
         ALERT_OUT_N     <= ~next_status;
      end
   end

   // ======================================================================
   // response sequencer
   ocf_state_t       st;
   ocf_state_t       next_st;
   logic [2:0]       tries;
   logic [2:0]       next_tries;
   logic             next_out;
   logic             do_shut;
   logic             give_up;
   logic [1:0]       resp;
   logic [2:0]       retry;
   logic [2:0]       tcode;
   logic [TMR_W-1:0] dly;
   logic [TMR_W-1:0] hic;

   always_comb begin
      resp  = act[ACT_RESP_HI:ACT_RESP_LO];
      retry = act[ACT_RETRY_HI:ACT_RETRY_LO];
      tcode = act[ACT_TIME_HI:ACT_TIME_LO];
      dly   = (tcode < 3'h2) ? DLY_1 : (tcode < 3'h5) ? DLY_3 : DLY_7;
      hic   = (tcode < 3'h2) ? RISE_CYC : TMR_W'(tcode) * RISE_CYC;
      // code 000 gives up at once, code 111 never does
      give_up  = (retry != RETRY_EVER) && (tries >= retry);
      next_st  = st;
      next_tries = tries;
      tmr_load = 1'b0;
      tmr_val  = RISE_CYC;
      do_shut  = 1'b0;
      unique case (st)
         ST_IDLE: begin
            if (OP_ENABLE)
               next_st = ST_RUN;
         end
         ST_RUN, ST_RISE: begin
            if (over_any && resp == RESP_NOW) begin
               do_shut = 1'b1;
            end else if (over_any && resp == RESP_DELAY) begin
               next_st  = ST_DELAY;
               tmr_load = 1'b1;
               tmr_val  = dly;
            end else if (st == ST_RISE && tmr_done) begin
               next_st    = ST_RUN;
               next_tries = 3'h0;
            end
         end
         ST_DELAY: begin
            if (tmr_done)
               do_shut = 1'b1;
         end
         ST_HICCUP: begin
            if (tmr_done) begin
               next_st    = ST_RISE;
               next_tries = (tries == 3'h7) ? tries : tries + 3'h1;
               tmr_load   = 1'b1;
               tmr_val    = RISE_CYC;
            end
         end
         ST_OFF: begin
            if (FAULT_CLEAR && retry <= RETRY_ONCE) begin
               next_st    = ST_IDLE;
               next_tries = 3'h0;
            end
         end
      endcase
      if (do_shut) begin
         if (give_up) begin
            next_st = ST_OFF;
         end else begin
            next_st  = ST_HICCUP;
            tmr_load = 1'b1;
            tmr_val  = hic;
         end
      end
      // disabling the output ends a retry run but never frees a latched one
      if (!OP_ENABLE && st != ST_OFF) begin
         next_st    = ST_IDLE;
         next_tries = 3'h0;
         tmr_load   = 1'b0;
      end
      tmr_tick = (st == ST_DELAY) ? pwm_tick : 1'b1;
      next_out = next_st inside {ST_RUN, ST_DELAY, ST_RISE};
   end

   always_ff @(posedge CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         st         <= ST_IDLE;
         tries      <= 3'h0;
         OUT_ENABLE <= 1'b0;
      end else begin
         st         <= next_st;
         tries      <= next_tries;
         OUT_ENABLE <= next_out;
      end
   end

   // ======================================================================
   // checks
   a_single_phase: assert property (@(posedge CLK) disable iff (SYS_RST)
      (CMD_WR && CMD_CODE == CMD_OC_LIM && phase <= PHASE_MAX)
      |=> b.limit[$past(phase[1:0])] == $past(CMD_WDATA))
      else $error("phase write missed its phase");
   a_all_phases: assert property (@(posedge CLK) disable iff (SYS_RST)
      (CMD_WR && CMD_CODE == CMD_OC_LIM && phase == PHASE_ALL)
      |=> b.limit[0] == $past(CMD_WDATA) && b.limit[NPH-1] == $past(CMD_WDATA))
      else $error("broadcast write missed a phase");
   a_stack_limit: assert property (@(posedge CLK) disable iff (SYS_RST)
      1 |=> TOTAL_LIMIT <= TOT_W'($past(b.real_q[0])) * TOT_W'(NPH)
            && TOTAL_LIMIT >= TOT_W'(LIM_MIN_Q) * TOT_W'(NPH))
      else $error("stack limit above lowest phase");
   a_alert_on_fault: assert property (@(posedge CLK) disable iff (SYS_RST)
      over_any |=> !ALERT_OUT_N && STATUS_OC_FAULT)
      else $error("fault without alert");
   a_ignore_runs: assert property (@(posedge CLK) disable iff (SYS_RST)
      (st == ST_RUN && OP_ENABLE && resp[1] == 1'b0) |=> OUT_ENABLE && st == ST_RUN)
      else $error("ignored fault stopped the output");
   a_delay_holds: assert property (@(posedge CLK) disable iff (SYS_RST)
      (st == ST_RUN && OP_ENABLE && over_any && resp == RESP_DELAY)
      |=> st == ST_DELAY ##1 (OUT_ENABLE || !$past(OP_ENABLE)))
      else $error("delayed shutdown cut short");
   a_now_stops: assert property (@(posedge CLK) disable iff (SYS_RST)
      (st inside {ST_RUN, ST_RISE} && over_any && resp == RESP_NOW) |=> !OUT_ENABLE)
      else $error("immediate shutdown late");
   a_latch_holds: assert property (@(posedge CLK) disable iff (SYS_RST)
      (st == ST_OFF && !(FAULT_CLEAR && retry <= RETRY_ONCE)) |=> st == ST_OFF && !OUT_ENABLE)
      else $error("latched output released");
   a_retry_bound: assert property (@(posedge CLK) disable iff (SYS_RST)
      (st == ST_RISE && retry != RETRY_EVER) |-> tries <= retry)
      else $error("too many restart attempts");
   a_hiccup_off: assert property (@(posedge CLK) disable iff (SYS_RST || !OP_ENABLE)
      (st != ST_HICCUP ##1 st == ST_HICCUP) |-> (!OUT_ENABLE && st == ST_HICCUP) [*8])
      else $error("hiccup gap too short");
   a_status_sticky: assert property (@(posedge CLK) disable iff (SYS_RST)
      (STATUS_OC_FAULT && !FAULT_CLEAR) |=> STATUS_OC_FAULT && !ALERT_OUT_N)
      else $error("fault status dropped without a clear");
   a_selector_kept: assert property (@(posedge CLK) disable iff (SYS_RST)
      (CMD_WR && CMD_CODE == CMD_PHASE && CMD_WDATA[7:0] > PHASE_MAX && CMD_WDATA[7:0] != PHASE_ALL)
      |=> phase == $past(phase))
      else $error("phase selector took a value that names no phase");
   a_rise_release: assert property (@(posedge CLK) disable iff (SYS_RST)
      (st == ST_RISE && tmr_done && !over_any && OP_ENABLE) |=> st == ST_RUN && OUT_ENABLE)
      else $error("clean restart did not resume regulation");
   a_clear_release: assert property (@(posedge CLK) disable iff (SYS_RST)
      (st == ST_OFF && FAULT_CLEAR && retry <= RETRY_ONCE) |=> st == ST_IDLE)
      else $error("cleared latch did not release");

endmodule

// file: tb/ocf_host.sv
// host-side model of the command port: issues register writes and reads
module ocf_host (
   input  wire logic        clk,
   output logic [7:0]       cmd_code,
   output logic [15:0]      cmd_wdata,
   output logic             cmd_wr,
   output logic             cmd_rd,
   input  wire logic [15:0] rd_data,
   input  wire logic        rd_valid
);
   timeunit 1ns;
   timeprecision 100ps;

   initial begin
      cmd_code  = 8'h00;
      cmd_wdata = 16'h0000;
      cmd_wr    = 1'b0;
      cmd_rd    = 1'b0;
   end

   // ======================================================================
   // one access per call, strobe held for exactly one taking edge
   task automatic wr(input logic [7:0] code, input logic [15:0] data);
      @(posedge clk);
      cmd_code  <= code;
      cmd_wdata <= data;
      cmd_wr    <= 1'b1;
      @(posedge clk);
      cmd_wr    <= 1'b0;
      // released data is inverted so a stale word cannot pose as a fresh one
      cmd_wdata <= ~data;
   endtask

   task automatic rd(input logic [7:0] code, output logic [15:0] data, output logic valid);
      @(posedge clk);
      cmd_code <= code;
      cmd_rd   <= 1'b1;
      @(posedge clk);
      cmd_rd   <= 1'b0;
      #1;
      valid = rd_valid;
      data  = rd_data;
   endtask
endmodule

// file: tb/ocf_tb_top.sv
// self-checking bench for the overcurrent threshold bank and fault sequencer
module ocf_tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   import ocf_pkg::*;

   logic                        clk = 1'b0;
   logic                        sys_rst = 1'b1;
   logic [7:0]                  cmd_code;
   logic [15:0]                 cmd_wdata;
   logic                        cmd_wr;
   logic                        cmd_rd;
   logic [NPH-1:0][CUR_W-1:0]   peak_cur = '0;
   logic                        op_enable = 1'b1;
   logic                        fault_clear = 1'b0;
   logic [15:0]                 rd_data;
   logic                        rd_valid;
   logic                        out_enable;
   logic                        alert_out_n;
   logic                        status_oc_fault;
   logic [TOT_W-1:0]            total_limit;
   int                          errors = 0;
   int                          total_checks = 0;
   int                          n;
   int                          p;

   always #2 clk = ~clk;

   ocf_top u_ocf_top (.CLK(clk), .SYS_RST(sys_rst), .CMD_CODE(cmd_code), .CMD_WDATA(cmd_wdata),
      .CMD_WR(cmd_wr), .CMD_RD(cmd_rd), .PEAK_CUR(peak_cur), .OP_ENABLE(op_enable),
      .FAULT_CLEAR(fault_clear), .RD_DATA(rd_data), .RD_VALID(rd_valid), .OUT_ENABLE(out_enable),
      .ALERT_OUT_N(alert_out_n), .STATUS_OC_FAULT(status_oc_fault), .TOTAL_LIMIT(total_limit));

   ocf_host u_ocf_host (.clk(clk), .cmd_code(cmd_code), .cmd_wdata(cmd_wdata), .cmd_wr(cmd_wr),
      .cmd_rd(cmd_rd), .rd_data(rd_data), .rd_valid(rd_valid));

   // ======================================================================
   // helpers
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      total_checks++;
      if (got !== exp) begin
         errors++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic rchk(input logic [7:0] code, input logic [15:0] exp);
      logic [15:0] d;
      logic        v;
      u_ocf_host.rd(code, d, v);
      chk({15'h0000, v}, 16'h0001);
      chk(d, exp);
   endtask

   task automatic tick(input int k);
      repeat (k) @(posedge clk);
      #1;
   endtask

   task automatic do_reset();
      @(posedge clk);
      sys_rst  <= 1'b1;
      peak_cur <= '0;
      repeat (5) @(posedge clk);
      sys_rst <= 1'b0;
      tick(3);
   endtask

   task automatic over();
      @(posedge clk);
      peak_cur <= {NPH{10'h3FF}};
      tick(3);
   endtask

   // current must be low for a few edges first: a fault in the clear cycle wins
   task automatic calm();
      @(posedge clk);
      peak_cur <= '0;
      tick(3);
      @(posedge clk);
      fault_clear <= 1'b1;
      @(posedge clk);
      fault_clear <= 1'b0;
      tick(2);
   endtask

   task automatic wait_out(input logic val, input int lim, output int c);
      c = 0;
      while (out_enable !== val && c < lim) begin
         tick(1);
         c++;
      end
   endtask

   task automatic count_rises(input int win, output int c);
      logic p;
      c = 0;
      p = out_enable;
      repeat (win) begin
         tick(1);
         if (out_enable === 1'b1 && p !== 1'b1) c++;
         p = out_enable;
      end
   endtask

   task automatic end_of_test();
      $display("checks %0d errors %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   initial begin
      repeat (60000) @(posedge clk);
      errors++;
      end_of_test();
   end

   // ======================================================================
   // scenarios
   initial begin
      do_reset();
      rchk(CMD_OC_LIM, 16'hF0F8);
      rchk(CMD_OC_ACT, 16'h00C0);
      rchk(CMD_PHASE, 16'h00FF);
      chk({4'h0, total_limit}, 16'h03E0);
      rchk(8'h10, 16'h0000);
      u_ocf_host.wr(CMD_PHASE, 16'h0002);
      u_ocf_host.wr(CMD_OC_LIM, 16'hF0A0);
      rchk(CMD_OC_LIM, 16'hF0A0);
      tick(3);
      chk({4'h0, total_limit}, 16'h0280);
      u_ocf_host.wr(CMD_PHASE, 16'h0001);
      u_ocf_host.wr(CMD_OC_LIM, 16'hF0A6);
      tick(3);
      chk({4'h0, total_limit}, 16'h0280);
      u_ocf_host.wr(CMD_OC_LIM, 16'hF014);
      tick(3);
      chk({4'h0, total_limit}, 16'h0080);
      u_ocf_host.wr(CMD_PHASE, 16'h0005);
      rchk(CMD_PHASE, 16'h0001);
      rchk(CMD_OC_LIM, 16'hF014);
      u_ocf_host.wr(CMD_PHASE, 16'h00FF);
      u_ocf_host.wr(CMD_OC_LIM, 16'hF0C0);
      u_ocf_host.wr(CMD_PHASE, 16'h0003);
      rchk(CMD_OC_LIM, 16'hF0C0);
      tick(3);
      chk({4'h0, total_limit}, 16'h0300);
      // ignore mode: flags raised, output untouched
      u_ocf_host.wr(CMD_OC_ACT, 16'h0000);
      over();
      chk({14'h0, alert_out_n, status_oc_fault}, 16'h0001);
      tick(100);
      chk({15'h0, out_enable}, 16'h0001);
      calm();
      chk({14'h0, alert_out_n, status_oc_fault}, 16'h0002);
      // delayed shutdown for each delay band
      for (int t = 0; t < 8; t += 3) begin
         do_reset();
         u_ocf_host.wr(CMD_OC_ACT, 16'(8'h80 | t));
         over();
         chk({15'h0, out_enable}, 16'h0001);
         wait_out(1'b0, 4000, n);
         p = (t == 0) ? 1 : (t == 3) ? 3 : 7;
         // the first switching tick may land anywhere in its period
         chk(16'(n > (p - 1) * PWM_CYC && n <= p * PWM_CYC), 16'h0001);
         chk({15'h0, out_enable}, 16'h0000);
      end
      // hiccup gap scales with the timing code
      for (int t = 0; t < 8; t += 4) begin
         do_reset();
         u_ocf_host.wr(CMD_OC_ACT, 16'(8'hC8 | t));
         over();
         wait_out(1'b1, 2000, n);
         chk(16'(n >= (t == 0 ? 1 : t) * 250 - 4 && n <= (t == 0 ? 1 : t) * 250 + 4), 16'h0001);
      end
      // every retry code: attempts counted, then release by clear or not
      for (int r = 0; r < 8; r++) begin
         do_reset();
         u_ocf_host.wr(CMD_OC_ACT, 16'(8'hC0 | (r << 3)));
         over();
         chk({15'h0, out_enable}, 16'h0000);
         chk({14'h0, alert_out_n, status_oc_fault}, 16'h0001);
         count_rises(2000, n);
         if (r == 7) begin
            chk(16'(n >= 7), 16'h0001);
            // dropping the enable must end an endless retry run
            @(posedge clk);
            op_enable <= 1'b0;
            tick(300);
            chk({15'h0, out_enable}, 16'h0000);
            @(posedge clk);
            op_enable <= 1'b1;
         end else begin
            chk(16'(n), 16'(r));
         end
         calm();
         tick(300);
         chk({15'h0, out_enable}, 16'(r < 2 || r == 7));
      end
      end_of_test();
   end
endmodule
